// File: rtl/sig_route_map.svh
// Register offsets, reset values, clock period and timing counts
`ifndef SIG_ROUTE_MAP_SVH
`define SIG_ROUTE_MAP_SVH
`define OFF_EVT_SEL 8'h00
`define OFF_OUT_ROUTE 8'h04
`define OFF_AND_A 8'h08
`define OFF_AND_B 8'h0C
`define OFF_OUT_MODE 8'h10
`define OFF_OS_WIDTH 8'h14
`define OFF_IN_ROUTE 8'h18
`define OFF_GP_OUT 8'h1C
`define OFF_STATUS 8'h20
`define OFF_CNT_STATUS 8'h24
`define OFF_EVT_CLR 8'h28
`define OFF_LATCH_CFG 8'h2C
`define OS_WIDTH_RST 16'h0001
`define EVT_SEL_RST 32'h0000_1111
`define CLK_MHZ 200
`define US_NS 1000
`define CLK_NS 5
`define TICK_CYC (`US_NS / `CLK_NS)
`define EVT_PULSE_NS 200
`define EVT_PULSE_CYC (`EVT_PULSE_NS / `CLK_NS)
`endif

// File: rtl/sig_route_pkg.sv
// Shared types for the signal routing block
package sig_route_pkg;
   typedef enum logic [2:0] {
      OS_IDLE = 3'b001,
      OS_HIGH = 3'b010,
      OS_WAIT = 3'b100
   } oneshot_state_t;
   typedef enum logic [2:0] {
      SRC_ADDR = 3'd0,
      SRC_PULSE = 3'd1,
      SRC_DIFF = 3'd2,
      SRC_CYCLE = 3'd3,
      SRC_START_PENDING_FLAG = 3'd4,
      SRC_DRIVE = 3'd5,
      SRC_ERROR = 3'd6,
      SRC_RDY = 3'd7
   } event_src_t;
endpackage

// File: rtl/oneshot_if.sv
// Trigger and pulse carrier between router and one-shot timer
`timescale 1ns/10ps
`default_nettype none
interface oneshot_if;
   logic trig;
   logic rise_sel;
   logic [15:0] width_us;
   logic pulse;
   modport ctl (output trig, output rise_sel, output width_us, input pulse);
   modport tmr (input trig, input rise_sel, input width_us, output pulse);
endinterface
`default_nettype wire

// File: rtl/oneshot_timer.sv
// One-shot pulse generator counting microsecond ticks
`timescale 1ns/10ps
`default_nettype none
`include "sig_route_map.svh"
module oneshot_timer
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Tick and channel
   input wire logic us_tick,
   oneshot_if.tmr os
);
   sig_route_pkg::oneshot_state_t state_q;
   sig_route_pkg::oneshot_state_t state_d;
   logic trig_q;
   logic [15:0] cnt_q;
   wire edge_hit = os.rise_sel ? (os.trig & ~trig_q) : (~os.trig & trig_q);
   wire cnt_done = (cnt_q >= os.width_us);
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         sig_route_pkg::OS_IDLE: if (edge_hit) state_d = sig_route_pkg::OS_HIGH;
         sig_route_pkg::OS_HIGH: if (cnt_done) state_d = sig_route_pkg::OS_IDLE;
         default: state_d = sig_route_pkg::OS_IDLE;
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= sig_route_pkg::OS_IDLE;
         trig_q <= 1'b0;
         cnt_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         trig_q <= os.trig;
         // Retriggers during the pulse are ignored
         if (state_q != sig_route_pkg::OS_HIGH)
            cnt_q <= 16'h0000;
         else if (us_tick)
            cnt_q <= cnt_q + 16'h0001;
      end
   end
   assign os.pulse = (state_q == sig_route_pkg::OS_HIGH);
   chk_os_no_retrig: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (os.pulse && !cnt_done) |=> os.pulse && cnt_q >= $past(cnt_q))
      else $error("one-shot cut short or restarted");
endmodule
`default_nettype wire

// File: rtl/external_signal_routing.sv
// External signal routing: event selection, output lines, input mapping
// What this block does
// - General output command accepted anytime
// - Each line driven by chosen axis event
// - Event output picks counter, standby, drive, error
// - Line through or one-shot, microsecond width
// - Line may be AND of two axes
// - Active source turns line on
// - Pulse counter event defaults to 200ns pulse
// - Counter events latch until status read or clear
// - Complete event on drive end or busy fall
// - Complete event cleared by read, command, busy
// - Counter event is OR of three comparators
// - Counter event drops when comparators clear
// - Inputs assignable as axis sensor zero/one
// - Sensor input switches drive phase
// - Sensor input triggers cycle measurement
// - Input gives slow or immediate stop
// - Pause input holds axis start
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sig_route_map.svh"
module external_signal_routing
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Per-axis motion state, three comparators per counter
   input wire logic [3:0][3:0][2:0] comparator_out,
   input wire logic [3:0] start_pending_flag,
   input wire logic [3:0] drive_busy,
   input wire logic [3:0] drive_end_flag,
   input wire logic [3:0] drive_error,
   // External pins
   input wire logic sensor_input_zero,
   input wire logic sensor_input_one,
   input wire logic [3:0] external_input_lines,
   output logic [3:0] external_output_lines,
   output logic general_output,
   // Per-axis functions fed by inputs, then per-axis selected event outputs
   output logic [3:0] axis_sensor_zero,
   output logic [3:0] axis_sensor_one,
   output logic [3:0] axis_slow_stop,
   output logic [3:0] axis_fast_stop,
   output logic [3:0] axis_pause,
   output logic [3:0] axis_phase_up,
   output logic [3:0] axis_phase_down,
   output logic [3:0] axis_cycle_trig,
   output logic [3:0] axis_event_out_first,
   output logic [3:0] axis_event_out_second
);
   logic [31:0] evt_sel_q, out_route_q, and_a_q, and_b_q, out_mode_q;
   logic [15:0] os_width_q;
   logic [31:0] in_route_q, latch_cfg_q;
   logic gp_out_q;
   logic [7:0] awaddr_q, araddr_q;
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [31:0] wdata_q, rdata_q, rd_mux;
   logic [1:0] bresp_q, rresp_q;
   logic [3:0] busy_q, rdy_q, end_q;
   logic [3:0][3:0] cnt_raw_q, cnt_lat_q;
   logic [3:0][5:0] stretch_q;
   logic [7:0] tick_q;
   logic [3:0] os_pulse;
   // Write channel accepts address and data in either order
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   wire wr_go = aw_have_q && w_have_q;
   wire [7:0] wa = awaddr_q;
   wire wr_hit = wa <= `OFF_LATCH_CFG;
   wire rd_go = s_axi_arvalid && s_axi_arready;
   assign s_axi_arready = !rvalid_q;
   wire rd_hit = s_axi_araddr <= `OFF_LATCH_CFG;
   wire rd_status = rd_go && s_axi_araddr == `OFF_STATUS;
   wire rd_cnt = rd_go && s_axi_araddr == `OFF_CNT_STATUS;
   wire clr_cmd = wr_go && wa == `OFF_EVT_CLR;
   wire gp_cmd = wr_go && wa == `OFF_GP_OUT;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   wire us_tick = tick_q == 8'(`TICK_CYC - 1);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         bresp_q <= 2'b00;
         rresp_q <= 2'b00;
         rdata_q <= 32'h0000_0000;
         tick_q <= 8'h00;
      end
      else
      begin
         tick_q <= us_tick ? 8'h00 : tick_q + 8'h01;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? 2'b00 : 2'b10;
         end
         else if (s_axi_bready)
            bvalid_q <= 1'b0;
         if (rd_go)
         begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? 2'b00 : 2'b10;
            rdata_q <= rd_mux;
         end
         else if (s_axi_rready)
            rvalid_q <= 1'b0;
      end
   end
   // Configuration registers; wstrb ignored, whole-word writes assumed
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         evt_sel_q <= `EVT_SEL_RST;
         out_route_q <= 32'h0000_0000;
         and_a_q <= 32'h0000_0000;
         and_b_q <= 32'h0000_0000;
         out_mode_q <= 32'h0000_0000;
         os_width_q <= `OS_WIDTH_RST;
         in_route_q <= 32'h0000_0000;
         latch_cfg_q <= 32'h0000_0000;
         gp_out_q <= 1'b0;
      end
      else if (wr_go)
      begin
         case (wa)
            `OFF_EVT_SEL: evt_sel_q <= wdata_q;
            `OFF_OUT_ROUTE: out_route_q <= wdata_q;
            `OFF_AND_A: and_a_q <= wdata_q;
            `OFF_AND_B: and_b_q <= wdata_q;
            `OFF_OUT_MODE: out_mode_q <= wdata_q;
            `OFF_OS_WIDTH: os_width_q <= wdata_q[15:0];
            `OFF_IN_ROUTE: in_route_q <= wdata_q;
            `OFF_LATCH_CFG: latch_cfg_q <= wdata_q;
            `OFF_GP_OUT: gp_out_q <= wdata_q[0];
            default: ;
         endcase
      end
   end
   assign general_output = gp_out_q;
   always_comb
   begin
      case (s_axi_araddr)
         `OFF_EVT_SEL: rd_mux = evt_sel_q;
         `OFF_OUT_ROUTE: rd_mux = out_route_q;
         `OFF_AND_A: rd_mux = and_a_q;
         `OFF_AND_B: rd_mux = and_b_q;
         `OFF_OUT_MODE: rd_mux = out_mode_q;
         `OFF_OS_WIDTH: rd_mux = {16'h0000, os_width_q};
         `OFF_IN_ROUTE: rd_mux = in_route_q;
         `OFF_GP_OUT: rd_mux = {31'h0, gp_out_q};
         `OFF_STATUS: rd_mux = {28'h0, rdy_q};
         `OFF_CNT_STATUS: rd_mux = {16'h0, cnt_lat_q};
         `OFF_LATCH_CFG: rd_mux = latch_cfg_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   // Per-axis event generation
   logic [3:0][7:0] src_vec;
   genvar ax;
   generate
      for (ax = 0; ax < 4; ax++)
      begin : g_axis
         wire [3:0] raw;
         wire [3:0] ev;
         wire [1:0] ltype = latch_cfg_q[ax*2 +: 2];
         // Complete event fires on drive end rising or busy falling
         wire done_edge = (drive_end_flag[ax] & ~end_q[ax])
            | (busy_q[ax] & ~drive_busy[ax]);
         for (genvar c = 0; c < 4; c++)
         begin : g_cnt
            assign raw[c] = |comparator_out[ax][c];
            // Type 0 through, 1 edge/status, 2 level/status, 3 edge/clear
            assign ev[c] = (ltype == 2'd0) ?
               ((c == 1) ? (stretch_q[ax] != 6'd0) : raw[c])
               : cnt_lat_q[ax][c];
         end
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               cnt_raw_q[ax] <= 4'h0;
               cnt_lat_q[ax] <= 4'h0;
               stretch_q[ax] <= 6'd0;
               busy_q[ax] <= 1'b0;
               end_q[ax] <= 1'b0;
               rdy_q[ax] <= 1'b0;
            end
            else
            begin
               cnt_raw_q[ax] <= raw;
               busy_q[ax] <= drive_busy[ax];
               end_q[ax] <= drive_end_flag[ax];
               if (raw[1] & ~cnt_raw_q[ax][1])
                  stretch_q[ax] <= 6'(`EVT_PULSE_CYC);
               else if (stretch_q[ax] != 6'd0)
                  stretch_q[ax] <= stretch_q[ax] - 6'd1;
               if (ltype == 2'd2)
                  cnt_lat_q[ax] <= raw | (rd_cnt ? 4'h0 : cnt_lat_q[ax]);
               else if (ltype == 2'd0)
                  cnt_lat_q[ax] <= raw;
               else if ((ltype == 2'd1 && rd_cnt) || (ltype == 2'd3 && clr_cmd))
                  cnt_lat_q[ax] <= raw & ~cnt_raw_q[ax];
               else
                  cnt_lat_q[ax] <= cnt_lat_q[ax] | (raw & ~cnt_raw_q[ax]);
               if (done_edge)
                  rdy_q[ax] <= 1'b1;
               else if (rd_status | gp_cmd | (drive_busy[ax] & ~busy_q[ax]))
                  rdy_q[ax] <= 1'b0;
            end
         end
         assign src_vec[ax] = {rdy_q[ax], drive_error[ax], drive_busy[ax],
            start_pending_flag[ax], ev};
         assign axis_event_out_first[ax] = src_vec[ax][evt_sel_q[ax*8 +: 3]];
         assign axis_event_out_second[ax] =
            src_vec[ax][evt_sel_q[ax*8+4 +: 3]];
      end
   endgenerate
   // Output lines: AND of two selected axis events, then through or one-shot
   genvar ln;
   generate
      for (ln = 0; ln < 4; ln++)
      begin : g_line
         wire [7:0] a = and_a_q[ln*8 +: 8];
         wire [7:0] b = and_b_q[ln*8 +: 8];
         wire sa = a[2] ? axis_event_out_second[a[1:0]]
            : axis_event_out_first[a[1:0]];
         wire sb = b[2] ? axis_event_out_second[b[1:0]]
            : axis_event_out_first[b[1:0]];
         wire src = out_route_q[ln] & sa & sb;
         oneshot_if osi ();
         assign osi.trig = src;
         assign osi.rise_sel = ~out_mode_q[ln+4];
         assign osi.width_us = os_width_q;
         assign os_pulse[ln] = osi.pulse;
         oneshot_timer u_os (
            .aclk(aclk),
            .aresetn(aresetn),
            .us_tick(us_tick),
            .os(osi.tmr)
         );
         assign external_output_lines[ln] =
            out_mode_q[ln] ? os_pulse[ln] : src;
      end
   endgenerate
   // Input routing: 6 sources, each 5-bit field {func[2:0] no, axis[1:0]}
   wire [5:0] in_pins = {external_input_lines, sensor_input_one,
      sensor_input_zero};
   generate
      for (ax = 0; ax < 4; ax++)
      begin : g_in
         logic [7:0] hit;
         always_comb
         begin
            hit = 8'h00;
            for (int i = 0; i < 6; i++)
               if (in_route_q[i*5 +: 2] == 2'(ax) && in_pins[i])
                  hit[in_route_q[i*5+2 +: 3]] = 1'b1;
         end
         assign axis_sensor_zero[ax] = hit[1];
         assign axis_sensor_one[ax] = hit[2];
         assign axis_phase_up[ax] = hit[3];
         assign axis_phase_down[ax] = hit[4];
         assign axis_cycle_trig[ax] = hit[5];
         assign axis_slow_stop[ax] = hit[6];
         assign axis_fast_stop[ax] = hit[7];
         assign axis_pause[ax] = hit[0];
      end
   endgenerate
   chk_rdy_set_edge: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (busy_q[3] && !drive_busy[3]) |=> rdy_q[3])
      else $error("complete event not raised");
   chk_rdy_clear_read: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rd_status && !(busy_q[3] && !drive_busy[3])
       && !(drive_end_flag[3] && !end_q[3])) |=> !rdy_q[3])
      else $error("complete event not cleared");
   chk_gp_out_apply: assert property (
      @(posedge aclk) disable iff (!aresetn)
      gp_cmd |=> general_output == $past(wdata_q[0]))
      else $error("general output not applied");
   chk_line_through: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !out_mode_q[0] |-> external_output_lines[0] == g_line[0].src)
      else $error("through line mismatch");
   chk_pulse_stretch: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (g_axis[2].raw[1] && !cnt_raw_q[2][1] && latch_cfg_q[5:4] == 2'd0)
      |=> g_axis[2].ev[1] [*8])
      else $error("pulse event too short");
endmodule
`default_nettype wire

// File: verification/ext_equipment.sv
// Camera-like receiver that times pulses on one external output line
`timescale 1ns/10ps
`default_nettype none
module ext_equipment
(
   // Clock and control
   input wire logic aclk,
   input wire logic clr,
   // Line from the block, high means conducting
   input wire logic line,
   // Observations
   output logic [31:0] width,
   output logic [31:0] rises
);
   logic [31:0] run_q = 0;
   logic last_q = 0;
   initial width = 0;
   initial rises = 0;
   // Counts each on period and keeps the length of the last one
   always @(posedge aclk)
   begin
      last_q <= line;
      run_q <= line ? run_q + 1 : 0;
      if (clr)
         rises <= 0;
      else if (line && !last_q)
         rises <= rises + 1;
      if (!line && last_q)
         width <= run_q;
   end
endmodule
`default_nettype wire

// File: verification/external_signal_routing_test.sv
// Self-checking bench for the external signal routing block
`timescale 1ns/10ps
`default_nettype none
`include "sig_route_map.svh"
module external_signal_routing_test;
   logic aclk = 0, aresetn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [3:0][3:0][2:0] comparator_out = 0;
   logic [3:0] start_pending_flag = 0, drive_busy = 0;
   logic [3:0] drive_end_flag = 0, drive_error = 0;
   logic sensor_input_zero = 0, sensor_input_one = 0;
   logic [3:0] external_input_lines = 0;
   logic [3:0] external_output_lines, axis_sensor_zero, axis_sensor_one;
   logic [3:0] axis_slow_stop, axis_fast_stop, axis_pause, axis_phase_up;
   logic [3:0] axis_phase_down, axis_cycle_trig;
   logic [3:0] axis_event_out_first, axis_event_out_second;
   logic general_output, cam_clr = 0;
   logic [31:0] cam_w, cam_n, d, in_fn;
   int bad_count = 0, tests_run = 0, cycles = 0;
   typedef struct packed {logic [7:0] a; logic [31:0] v;} row_t;
   row_t rows [8] = '{'{8'h00, 32'h0065_4321}, '{8'h04, 32'h0000_000F},
      '{8'h08, 32'h0302_0100}, '{8'h0C, 32'h0407_0605},
      '{8'h10, 32'h0000_00A5}, '{8'h14, 32'h0000_FFFF},
      '{8'h18, 32'h0123_4567}, '{8'h2C, 32'h0000_00E4}};
   assign in_fn = {axis_fast_stop, axis_slow_stop, axis_cycle_trig,
      axis_phase_down, axis_phase_up, axis_sensor_one, axis_sensor_zero,
      axis_pause};

   external_signal_routing i_dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .comparator_out, .start_pending_flag, .drive_busy, .drive_end_flag,
      .drive_error, .sensor_input_zero, .sensor_input_one,
      .external_input_lines, .external_output_lines, .general_output,
      .axis_sensor_zero, .axis_sensor_one, .axis_slow_stop, .axis_fast_stop,
      .axis_pause, .axis_phase_up, .axis_phase_down, .axis_cycle_trig,
      .axis_event_out_first, .axis_event_out_second);
   ext_equipment i_cam (.aclk, .clr(cam_clr),
      .line(external_output_lines[0]), .width(cam_w), .rises(cam_n));

   always #2.5 aclk = ~aclk;

   task automatic results;
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         bad_count = bad_count + 1;
         results();
      end
   end

   task automatic chk(input string n, input logic [31:0] seen, exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] r);
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (!b)
      begin
         @(negedge aclk);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] r);
      logic ar, got;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      got = 1'b0;
      while (!got)
      begin
         @(negedge aclk);
         ar = s_axi_arvalid & s_axi_arready;
         got = s_axi_rvalid;
         v = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar)
            s_axi_arvalid <= 1'b0;
      end
   endtask

   task automatic cfg(input logic [7:0] a, input logic [31:0] v);
      wr(a, v, rsp);
   endtask

   // Raises or drops the chosen event source of axis 2
   task automatic src(input int s, input logic on);
      if (s < 4)
         comparator_out[2][s][s % 3] <= on;
      else if (s == 4)
         start_pending_flag[2] <= on;
      else if (s == 5)
         drive_busy[2] <= on;
      else
         drive_error[2] <= on;
   endtask

   task automatic blip(input int ax, input int k);
      comparator_out[ax][1][k] <= 1'b1;
      cyc(2);
      comparator_out[ax][1][k] <= 1'b0;
   endtask

   initial
   begin
      cyc(8);
      aresetn <= 1'b1;
      cyc(1);
      chk("out_lines", external_output_lines, 0);
      chk("gp_out", general_output, 0);
      rd(8'h00, d, rsp);
      chk("evt_sel_rst", d, `EVT_SEL_RST);
      rd(8'h14, d, rsp);
      chk("width_rst", d, `OS_WIDTH_RST);
      foreach (rows[i])
      begin
         cfg(rows[i].a, rows[i].v);
         rd(rows[i].a, d, rsp);
         chk("readback", d, rows[i].v);
      end
      rd(8'h30, d, rsp);
      chk("bad_rd_resp", rsp, 2'b10);
      chk("bad_rd_data", d, 0);
      wr(8'h34, 32'h1234_5678, rsp);
      chk("bad_wr_resp", rsp, 2'b10);
      // Each source of axis 2 first output except the complete event (7) routed through line 1
      cfg(8'h08, 32'h0000_0200);
      cfg(8'h0C, 32'h0000_0200);
      cfg(8'h04, 32'h0000_0002);
      cfg(8'h10, 0);
      cfg(8'h2C, 0);
      for (int s = 0; s < 7; s++)
      begin
         cfg(8'h00, 32'(s) << 16);
         src(s, 1'b1);
         cyc(3);
         chk("evt_first", axis_event_out_first[2], 1'b1);
         chk("line1_on", external_output_lines[1], 1'b1);
         src(s, 1'b0);
         cyc(45);
         chk("line1_off", external_output_lines[1], 1'b0);
      end
      // Command complete on axis 3 second output, line 2
      cfg(8'h00, 32'h7000_0000);
      cfg(8'h08, 32'h0007_0000);
      cfg(8'h0C, 32'h0007_0000);
      cfg(8'h04, 32'h0000_0004);
      drive_end_flag[3] <= 1'b1;
      cyc(3);
      chk("rdy_end", axis_event_out_second[3], 1'b1);
      chk("line2_rdy", external_output_lines[2], 1'b1);
      rd(8'h20, d, rsp);
      chk("status_rdy", d[3], 1'b1);
      cyc(2);
      chk("rdy_rd_clr", axis_event_out_second[3], 1'b0);
      drive_end_flag[3] <= 1'b0;
      drive_busy[3] <= 1'b1;
      cyc(3);
      drive_busy[3] <= 1'b0;
      cyc(3);
      chk("rdy_busy", axis_event_out_second[3], 1'b1);
      cfg(8'h1C, 0);
      cyc(2);
      chk("rdy_gp_clr", axis_event_out_second[3], 1'b0);
      drive_busy[3] <= 1'b1;
      cyc(3);
      drive_busy[3] <= 1'b0;
      cyc(3);
      drive_busy[3] <= 1'b1;
      cyc(3);
      chk("rdy_busy_clr", axis_event_out_second[3], 1'b0);
      // AND of axes 0 and 1 with latched pulse counter events
      cfg(8'h00, 32'h0000_0101);
      cfg(8'h08, 32'h0000_0000);
      cfg(8'h0C, 32'h0000_0001);
      cfg(8'h04, 32'h0000_0001);
      for (int t = 0; t < 2; t++)
      begin
         cfg(8'h2C, t ? 32'h0000_0005 : 32'h0000_000F);
         blip(0, t);
         cyc(50);
         chk("and_one", external_output_lines[0], 1'b0);
         blip(1, 2);
         cyc(50);
         chk("and_both", external_output_lines[0], 1'b1);
         if (t)
            rd(8'h24, d, rsp);
         else
            cfg(8'h28, 32'hFFFF_FFFF);
         cyc(2);
         chk("latch_clr", external_output_lines[0], 1'b0);
      end
      // One-shot of 2 us on line 0, retriggered mid-pulse
      cfg(8'h00, 0);
      cfg(8'h0C, 0);
      cfg(8'h2C, 0);
      cfg(8'h14, 2);
      // Let a pulse left from the long width run out first
      cyc(500);
      cfg(8'h10, 32'h0000_0001);
      cam_clr <= 1'b1;
      cyc(2);
      cam_clr <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         comparator_out[0][0][0] <= 1'b1;
         cyc(10);
         comparator_out[0][0][0] <= 1'b0;
         cyc(150);
      end
      cyc(500);
      chk("os_count", cam_n, 1);
      chk("os_width", cam_w >= `TICK_CYC && cam_w <= 2 * `TICK_CYC + 4,
         1);
      cfg(8'h10, 32'h0000_0011);
      comparator_out[0][0][0] <= 1'b1;
      cyc(20);
      chk("os_fall_wait", external_output_lines[0], 1'b0);
      comparator_out[0][0][0] <= 1'b0;
      cyc(5);
      chk("os_fall_fire", external_output_lines[0], 1'b1);
      // Each input function on sensor input zero, one axis each
      for (int f = 0; f < 8; f++)
      begin
         cfg(8'h18, 32'(f * 4 + f % 4));
         sensor_input_zero <= 1'b1;
         cyc(2);
         chk("in_map", in_fn, 32'h1 << (4 * f + f % 4));
         sensor_input_zero <= 1'b0;
         cyc(2);
         chk("in_idle", in_fn, 0);
      end
      drive_busy <= 4'hF;
      cfg(8'h1C, 1);
      cyc(2);
      chk("gp_busy", general_output, 1'b1);
      aresetn <= 1'b0;
      cyc(2);
      aresetn <= 1'b1;
      cyc(1);
      chk("gp_reset", general_output, 1'b0);
      results();
   end
endmodule
`default_nettype wire
